// ==== verilog/sca_pkg.sv ====
// Package of types and constants for the shift and compare ALU slice
package sca_pkg;

  // ==========================================================
  // Widths and reset values
  localparam int SCA_BYTE_W = 8;
  localparam int SCA_SHIFT_W = 3;
  localparam int SCA_ADDR_W = 16;
  localparam logic [7:0] SCA_BYTE_RST = 8'h00;
  localparam logic [15:0] SCA_ADDR_RST = 16'h0000;

  // ==========================================================
  // Operations handled by the slice
  typedef enum logic [2:0] {
    SCA_OP_MSHL,
    SCA_OP_MSHR,
    SCA_OP_MSHRA,
    SCA_OP_CMPI,
    SCA_OP_CMPR,
    SCA_OP_CMPM
  } sca_op_t;

  // ==========================================================
  // Request from the decoder and register file
  typedef struct packed {
    sca_op_t op;
    logic [SCA_BYTE_W-1:0] reg_a;
    logic [SCA_BYTE_W-1:0] reg_b;
    logic [SCA_BYTE_W-1:0] imm;
    logic [SCA_SHIFT_W-1:0] shift;
    logic [SCA_ADDR_W-1:0] eaddr;
  } sca_req_t;

  typedef struct packed {
    logic carry;
    logic ovf;
    logic zero;
  } sca_flags_t;

  localparam sca_flags_t SCA_FLAGS_RST = '{carry: 1'b0, ovf: 1'b0, zero: 1'b0};

  typedef struct packed {
    logic [SCA_BYTE_W-1:0] diff;
    sca_flags_t flags;
  } sca_cmp_t;

endpackage : sca_pkg

// ==== verilog/sca_shifter.sv ====
// Combinational multiply-shift unit producing the 16-bit product
module sca_shifter
  import sca_pkg::*;
(
  input wire sca_op_t op,
  input wire logic [SCA_BYTE_W-1:0] value,
  input wire logic [SCA_SHIFT_W-1:0] shift,
  output logic [2*SCA_BYTE_W-1:0] product
);

  // ==========================================================
  // Products
  // Right forms are value * 2^(8-shift), i.e. {value,0} moved right
  wire [15:0] left_prod;
  wire [15:0] right_prod;
  wire [15:0] arith_prod;

  assign left_prod = {SCA_BYTE_RST, value} << shift;
  assign right_prod = {value, SCA_BYTE_RST} >> shift;
  // Sign bit refills the vacated upper bits
  assign arith_prod = $signed({value, SCA_BYTE_RST}) >>> shift;

  assign product = (op == SCA_OP_MSHL) ? left_prod :
                   (op == SCA_OP_MSHRA) ? arith_prod : right_prod;

endmodule : sca_shifter

// ==== verilog/sca_alu.sv ====
// Shift and compare ALU slice: multiply-shift and compare instructions
// Contract
// - Left multiply-shift gives reg times 2^shift, low byte to acc, high byte to reg.
// - Right multiply-shift gives reg times 2^(8-shift), low byte to acc, high byte to reg.
// - Compare with immediate puts immediate minus reg into acc.
// - Register compare puts second register minus first register into acc.
// - Memory compare reads data memory at the address and puts that byte minus reg in acc.
// - On a compare carry is cleared on borrow and set otherwise.
// - On a compare overflow is new carry and not new zero, meaning strictly greater.
// - Multiply-shifts leave all flags alone and change only acc and reg.
// - Every compare updates carry, overflow and zero together and writes acc.
module sca_alu
  import sca_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic req_valid,
  input wire sca_req_t req,
  input wire logic [SCA_BYTE_W-1:0] mem_rdata,
  output logic busy_ff,
  output logic mem_rd_en_ff,
  output logic [SCA_ADDR_W-1:0] mem_addr_ff,
  output logic [SCA_BYTE_W-1:0] acc_ff,
  output logic acc_we_ff,
  output logic [SCA_BYTE_W-1:0] reg_res_ff,
  output logic reg_we_ff,
  output sca_flags_t flags_ff,
  output logic flags_we_ff,
  output logic done_ff
);

  // ==========================================================
  // Compare arithmetic, shared by the immediate, register and memory forms
  function automatic sca_cmp_t cmp_sub(input logic [7:0] minuend, input logic [7:0] subtr);
    logic [8:0] wide;
    sca_cmp_t res;
    wide = {1'b0, minuend} - {1'b0, subtr};
    res.diff = wide[7:0];
    res.flags.carry = ~wide[8];
    res.flags.zero = (wide[7:0] == SCA_BYTE_RST);
    res.flags.ovf = res.flags.carry & ~res.flags.zero;
    return res;
  endfunction : cmp_sub

  // ==========================================================
  // State
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_MEM_REQ,
    ST_MEM_DATA
  } sca_state_t;

  sca_state_t state_ff;
  sca_state_t nxt_state;
  logic [SCA_BYTE_W-1:0] opnd_ff;

  // ==========================================================
  // Decode
  wire take;
  wire is_shift;
  wire is_cmp_now;
  wire is_cmp_mem;
  wire mem_done;
  wire [15:0] product;
  wire [7:0] minuend_now;
  sca_cmp_t cmp_now;
  sca_cmp_t cmp_mem;

  // New requests are taken only while idle; memory compares stall for two cycles
  assign take = req_valid && (state_ff == ST_IDLE);
  assign is_shift = (req.op == SCA_OP_MSHL) || (req.op == SCA_OP_MSHR) ||
                    (req.op == SCA_OP_MSHRA);
  assign is_cmp_now = (req.op == SCA_OP_CMPI) || (req.op == SCA_OP_CMPR);
  assign is_cmp_mem = (req.op == SCA_OP_CMPM);
  assign mem_done = (state_ff == ST_MEM_DATA);

  sca_shifter sca_shifter_inst (
    .op(req.op),
    .value(req.reg_a),
    .shift(req.shift),
    .product(product)
  );

  // reg_a is reg / reg1, reg_b is reg2
  assign minuend_now = (req.op == SCA_OP_CMPI) ? req.imm : req.reg_b;
  assign cmp_now = cmp_sub(minuend_now, req.reg_a);
  assign cmp_mem = cmp_sub(mem_rdata, opnd_ff);

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE:
      begin
        if (take && is_cmp_mem)
        begin
          nxt_state = ST_MEM_REQ;
        end
      end
      ST_MEM_REQ: nxt_state = ST_MEM_DATA;
      ST_MEM_DATA: nxt_state = ST_IDLE;
      // The fourth code of the state word is never entered; fall back to idle
      default: nxt_state = ST_IDLE;
    endcase
  end

  // ==========================================================
  // Next values of the outputs
  wire [7:0] nxt_acc;
  wire nxt_acc_we;
  wire [7:0] nxt_reg_res;
  wire nxt_reg_we;
  sca_flags_t nxt_flags;
  wire nxt_flags_we;
  wire nxt_mem_rd_en;
  wire [SCA_ADDR_W-1:0] nxt_mem_addr;
  wire [7:0] nxt_opnd;

  assign nxt_acc = mem_done ? cmp_mem.diff :
                   (take && is_shift) ? product[7:0] :
                   (take && is_cmp_now) ? cmp_now.diff : acc_ff;
  assign nxt_acc_we = (take && (is_shift || is_cmp_now)) || mem_done;
  assign nxt_reg_res = (take && is_shift) ? product[15:8] : reg_res_ff;
  assign nxt_reg_we = take && is_shift;
  // Shifts never reach the flag path
  assign nxt_flags = mem_done ? cmp_mem.flags :
                     (take && is_cmp_now) ? cmp_now.flags : flags_ff;
  assign nxt_flags_we = (take && is_cmp_now) || mem_done;
  assign nxt_mem_rd_en = take && is_cmp_mem;
  assign nxt_mem_addr = nxt_mem_rd_en ? req.eaddr : mem_addr_ff;
  // Register operand is held because the decoder may move on during the wait
  assign nxt_opnd = nxt_mem_rd_en ? req.reg_a : opnd_ff;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      state_ff <= ST_IDLE;
      opnd_ff <= SCA_BYTE_RST;
      busy_ff <= 1'b0;
      mem_rd_en_ff <= 1'b0;
      mem_addr_ff <= SCA_ADDR_RST;
      acc_ff <= SCA_BYTE_RST;
      acc_we_ff <= 1'b0;
      reg_res_ff <= SCA_BYTE_RST;
      reg_we_ff <= 1'b0;
      flags_ff <= SCA_FLAGS_RST;
      flags_we_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      opnd_ff <= nxt_opnd;
      busy_ff <= (nxt_state != ST_IDLE);
      mem_rd_en_ff <= nxt_mem_rd_en;
      mem_addr_ff <= nxt_mem_addr;
      acc_ff <= nxt_acc;
      acc_we_ff <= nxt_acc_we;
      reg_res_ff <= nxt_reg_res;
      reg_we_ff <= nxt_reg_we;
      flags_ff <= nxt_flags;
      flags_we_ff <= nxt_flags_we;
      done_ff <= nxt_acc_we;
    end
  end

  // ==========================================================
  // Checks
  wire [15:0] exp_shl;
  wire [15:0] exp_shr;
  wire [7:0] exp_imm_diff;
  wire [7:0] exp_reg_diff;
  wire [7:0] exp_mem_diff;

  assign exp_shl = {8'h00, req.reg_a} << req.shift;
  assign exp_shr = {req.reg_a, 8'h00} >> req.shift;
  assign exp_imm_diff = req.imm - req.reg_a;
  assign exp_reg_diff = req.reg_b - req.reg_a;
  assign exp_mem_diff = mem_rdata - opnd_ff;

  chk_mshl_result: assert property (@(posedge ref_clk) disable iff (reset)
    take && req.op == SCA_OP_MSHL |=> {reg_res_ff, acc_ff} == $past(exp_shl) && reg_we_ff)
    else $error("Left multiply-shift result wrong");

  chk_mshr_result: assert property (@(posedge ref_clk) disable iff (reset)
    take && req.op == SCA_OP_MSHR |=> {reg_res_ff, acc_ff} == $past(exp_shr) && acc_we_ff)
    else $error("Right multiply-shift result wrong");

  chk_mshra_sign: assert property (@(posedge ref_clk) disable iff (reset)
    take && req.op == SCA_OP_MSHRA && req.reg_a[7] |=> reg_res_ff[7] && acc_ff == $past(exp_shr[7:0]))
    else $error("Arithmetic shift lost the sign");

  chk_cmpi_diff: assert property (@(posedge ref_clk) disable iff (reset)
    take && req.op == SCA_OP_CMPI |=> acc_ff == $past(exp_imm_diff))
    else $error("Immediate compare difference wrong");

  chk_cmpr_diff: assert property (@(posedge ref_clk) disable iff (reset)
    take && req.op == SCA_OP_CMPR |=> acc_ff == $past(exp_reg_diff) && !reg_we_ff)
    else $error("Register compare difference wrong");

  chk_mem_sequence: assert property (@(posedge ref_clk) disable iff (reset)
    take && is_cmp_mem |=> mem_rd_en_ff && busy_ff ##1 !mem_rd_en_ff && busy_ff
      ##1 acc_we_ff && flags_we_ff && !busy_ff)
    else $error("Memory compare sequence wrong");

  chk_mem_diff: assert property (@(posedge ref_clk) disable iff (reset)
    mem_done |=> acc_ff == $past(exp_mem_diff))
    else $error("Memory compare difference wrong");

  chk_carry_borrow: assert property (@(posedge ref_clk) disable iff (reset)
    take && req.op == SCA_OP_CMPI |=> flags_ff.carry == ($past(req.imm) >= $past(req.reg_a)))
    else $error("Carry does not match borrow");

  chk_ovf_greater: assert property (@(posedge ref_clk) disable iff (reset)
    flags_we_ff |-> flags_ff.ovf == (flags_ff.carry && !flags_ff.zero))
    else $error("Overflow is not carry and not zero");

  chk_shift_flags: assert property (@(posedge ref_clk) disable iff (reset)
    take && is_shift |=> $stable(flags_ff) && !flags_we_ff)
    else $error("Multiply-shift touched the flags");

  chk_cmp_update: assert property (@(posedge ref_clk) disable iff (reset)
    take && is_cmp_now |=> acc_we_ff && flags_we_ff && done_ff)
    else $error("Compare did not write acc and flags");

  chk_zero_flag: assert property (@(posedge ref_clk) disable iff (reset)
    flags_we_ff |-> flags_ff.zero == (acc_ff == 8'h00))
    else $error("Zero flag does not match difference");

endmodule : sca_alu

// ==== tb/sca_mem_model.sv ====
// Data memory model: answers a read strobe with one byte in the next cycle
module sca_mem_model
  import sca_pkg::*;
(
  input wire logic ref_clk,
  input wire logic mem_rd_en_ff,
  input wire logic [SCA_ADDR_W-1:0] mem_addr_ff,
  output logic [SCA_BYTE_W-1:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Read path
  // Outside the data cycle the bus toggles, so a late sample never matches
  initial mem_rdata = 8'h00;
  always @(posedge ref_clk)
  begin
    if (mem_rd_en_ff)
      mem_rdata <= mem_addr_ff[7:0] ^ 8'h3C;
    else
      mem_rdata <= ~mem_rdata;
  end
endmodule : sca_mem_model

// ==== tb/sca_alu_tb.sv ====
// Self-checking bench for the shift and compare ALU slice
module sca_alu_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import sca_pkg::*;
  logic ref_clk, reset, req_valid, busy_ff, mem_rd_en_ff, acc_we_ff, reg_we_ff;
  logic flags_we_ff, done_ff;
  sca_req_t req;
  logic [7:0] mem_rdata, acc_ff, reg_res_ff;
  logic [15:0] mem_addr_ff;
  sca_flags_t flags_ff, exp_f;
  int n_errors = 0;
  int n_tests = 0;
  sca_alu sca_alu_inst (.ref_clk(ref_clk), .reset(reset), .req_valid(req_valid), .req(req),
    .mem_rdata(mem_rdata), .busy_ff(busy_ff), .mem_rd_en_ff(mem_rd_en_ff),
    .mem_addr_ff(mem_addr_ff), .acc_ff(acc_ff), .acc_we_ff(acc_we_ff), .reg_res_ff(reg_res_ff),
    .reg_we_ff(reg_we_ff), .flags_ff(flags_ff), .flags_we_ff(flags_we_ff), .done_ff(done_ff));
  sca_mem_model sca_mem_model_inst (.ref_clk(ref_clk), .mem_rd_en_ff(mem_rd_en_ff),
    .mem_addr_ff(mem_addr_ff), .mem_rdata(mem_rdata));
  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic op(input sca_op_t o, input logic [7:0] a, b, i, input logic [2:0] s,
    input logic [15:0] ea);
    int k;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req <= '{op: o, reg_a: a, reg_b: b, imm: i, shift: s, eaddr: ea};
    @(posedge ref_clk);
    req_valid <= 1'b0;
    #1;
    if (o == SCA_OP_CMPM)
    begin
      chk("rd_en", 16'h0001, {15'h0, mem_rd_en_ff});
      chk("busy", 16'h0001, {15'h0, busy_ff});
      chk("addr", ea, mem_addr_ff);
    end
    k = 0;
    while (done_ff !== 1'b1 && k < 8)
    begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    chk("done", 16'h0001, {15'h0, done_ff});
    if (o == SCA_OP_CMPM)
      chk("busy_end", 16'h0000, {15'h0, busy_ff});
  endtask : op
  task automatic do_shift(input sca_op_t o, input logic [7:0] a, input logic [2:0] s,
    input logic [15:0] p);
    op(o, a, 8'h00, 8'h00, s, 16'h0000);
    chk("acc", {8'h00, p[7:0]}, {8'h00, acc_ff});
    chk("reg", {8'h00, p[15:8]}, {8'h00, reg_res_ff});
    chk("reg_we", 16'h0001, {15'h0, reg_we_ff});
    chk("shift_acc_we", 16'h0001, {15'h0, acc_we_ff});
    chk("flags_we", 16'h0000, {15'h0, flags_we_ff});
    chk("flags", {13'h0, exp_f}, {13'h0, flags_ff});
  endtask : do_shift
  task automatic do_cmp(input sca_op_t o, input logic [7:0] ra, rb, im, input logic [15:0] ea,
    input logic [7:0] x, y);
    logic [7:0] d;
    d = x - y;
    exp_f = '{carry: x >= y, ovf: (x > y), zero: d == 8'h00};
    op(o, ra, rb, im, 3'h0, ea);
    chk("diff", {8'h00, d}, {8'h00, acc_ff});
    chk("flags", {13'h0, exp_f}, {13'h0, flags_ff});
    chk("flags_we", 16'h0001, {15'h0, flags_we_ff});
    chk("acc_we", 16'h0001, {15'h0, acc_we_ff});
    chk("cmp_reg_we", 16'h0000, {15'h0, reg_we_ff});
  endtask : do_cmp
  // ==========================================================
  // Scenarios
  task automatic t_shifts;
    for (int s = 0; s < 8; s++)
    begin
      do_shift(SCA_OP_MSHL, 8'hA5, s[2:0], 16'h00A5 << s);
      do_shift(SCA_OP_MSHR, 8'hA5, s[2:0], 16'h00A5 << (8 - s));
      do_shift(SCA_OP_MSHRA, 8'hA5, s[2:0], 16'($signed(16'hA500) >>> s));
      do_shift(SCA_OP_MSHRA, 8'h65, s[2:0], 16'h6500 >> s);
    end
  endtask : t_shifts
  task automatic t_compares;
    do_cmp(SCA_OP_CMPI, 8'h05, 8'h00, 8'h05, 16'h0000, 8'h05, 8'h05);
    do_cmp(SCA_OP_CMPI, 8'h04, 8'h00, 8'h03, 16'h0000, 8'h03, 8'h04);
    do_cmp(SCA_OP_CMPI, 8'hFF, 8'h00, 8'h00, 16'h0000, 8'h00, 8'hFF);
    do_cmp(SCA_OP_CMPI, 8'h01, 8'h00, 8'hC8, 16'h0000, 8'hC8, 8'h01);
    do_cmp(SCA_OP_CMPR, 8'h0A, 8'h14, 8'h00, 16'h0000, 8'h14, 8'h0A);
    do_cmp(SCA_OP_CMPR, 8'h14, 8'h0A, 8'h00, 16'h0000, 8'h0A, 8'h14);
    do_cmp(SCA_OP_CMPR, 8'h77, 8'h77, 8'h00, 16'h0000, 8'h77, 8'h77);
  endtask : t_compares
  task automatic t_memory;
    // Model content is address low byte xor 8'h3C
    do_cmp(SCA_OP_CMPM, 8'h08, 8'h00, 8'h00, 16'h1234, 8'h08, 8'h08);
    do_cmp(SCA_OP_CMPM, 8'h01, 8'h00, 8'h00, 16'h00FF, 8'hC3, 8'h01);
    do_cmp(SCA_OP_CMPM, 8'hFF, 8'h00, 8'h00, 16'hAB00, 8'h3C, 8'hFF);
    // Flags must survive a shift that follows a memory compare
    do_shift(SCA_OP_MSHL, 8'h81, 3'h1, 16'h0102);
  endtask : t_memory
  task automatic t_refuse;
    // A shift held during a memory compare must wait until busy_ff has fallen
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req <= '{op: SCA_OP_CMPM, reg_a: 8'h08, reg_b: 8'h00, imm: 8'h00, shift: 3'h0,
      eaddr: 16'h1234};
    @(posedge ref_clk);
    req <= '{op: SCA_OP_MSHL, reg_a: 8'h81, reg_b: 8'h00, imm: 8'h00, shift: 3'h1,
      eaddr: 16'h0000};
    repeat (2) @(posedge ref_clk);
    #1;
    chk("cmp_acc", 16'h0000, {8'h00, acc_ff});
    chk("cmp_flags", 16'h0005, {13'h0, flags_ff});
    chk("held_reg_we", 16'h0000, {15'h0, reg_we_ff});
    @(posedge ref_clk);
    req_valid <= 1'b0;
    #1;
    chk("late_acc", 16'h0002, {8'h00, acc_ff});
    chk("late_reg", 16'h0001, {8'h00, reg_res_ff});
  endtask : t_refuse
  task automatic t_reset;
    // Flags set and a memory compare in flight, so every checked reset value is seen to change
    do_cmp(SCA_OP_CMPI, 8'h01, 8'h00, 8'hC8, 16'h0000, 8'hC8, 8'h01);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req <= '{op: SCA_OP_CMPM, reg_a: 8'h01, reg_b: 8'h00, imm: 8'h00, shift: 3'h0,
      eaddr: 16'h00FF};
    @(posedge ref_clk);
    req_valid <= 1'b0;
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("acc_rst", 16'h0000, {8'h00, acc_ff});
    chk("flags_rst", 16'h0000, {13'h0, flags_ff});
    chk("busy_rst", 16'h0000, {15'h0, busy_ff});
    chk("reg_rst", 16'h0000, {8'h00, reg_res_ff});
    chk("rd_en_rst", 16'h0000, {15'h0, mem_rd_en_ff});
    exp_f = SCA_FLAGS_RST;
    @(posedge ref_clk);
    reset <= 1'b0;
  endtask : t_reset
  task print_verdict;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict
  // ==========================================================
  // Clock, reset, sequence and watchdog
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial
  begin
    reset = 1'b1;
    req_valid = 1'b0;
    req = '0;
    exp_f = SCA_FLAGS_RST;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    t_shifts();
    t_compares();
    t_memory();
    t_refuse();
    t_reset();
    t_compares();
    print_verdict();
  end
  // About 54 operations of a few cycles each fit well inside this span
  initial
  begin
    #100000;
    n_errors++;
    print_verdict();
  end
endmodule : sca_alu_tb
